/* logic/cpsb_shift_buffer.sv */
// How it works
// - slave only; 128 bits into shift buffer
// - active-low select gates clock and data
// - rising clock while selected shifts data in
// - falling clock drives far-end bit out
// - output feeds next device input for chaining
// - 8, 16 or 32-bit words all accepted
// - first bits: channel 15 of image d
// - channels descend to 0, 32 bits per image
// - images d, c, b, a follow in order
// - buffer msb ch15 d, lsb ch0 a
// - codes: 00 hiz, 01 neg, 10 pos, 11 gnd
// - transfer strobe copies slices into images
// - select strobe falling loads output, brief blank
// - reset clears buffer, images, outputs hiz
`timescale 1ns/1ps
`default_nettype none
`include "cpsb_params.svh"
module cpsb_shift_buffer
  import cpsb_pkg::*;
#(
  parameter int BUF_BITS = `CPSB_BUF_BITS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic sdi,
  output logic sdo,
  input wire logic buffer_transfer_strobe,
  input wire logic select_image_a_strobe,
  input wire logic select_image_b_strobe,
  input wire logic select_image_c_strobe,
  input wire logic select_image_d_strobe,
  output logic [31:0] high_voltage_output,
  output logic [15:0] output_driven,
  output logic word_valid,
  input wire logic word_ready
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  // every pin, strobes included, is asynchronous to mclk
  // the agree test drops a glitch shorter than one mclk period
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_q;
  logic [NPIN-1:0] s2_q;
  logic [NPIN-1:0] s3_q;
  logic [NPIN-1:0] clean_q;
  logic [NPIN-1:0] clean_prev_q;
  // pin order: sck, ss_n, sdi, transfer strobe, select a to d
  assign pin_raw = {select_image_d_strobe, select_image_c_strobe, select_image_b_strobe,
                    select_image_a_strobe, buffer_transfer_strobe, sdi, ss_n, sck};

  // stage flops; idle levels chosen as reset values
  // so that no false edge follows reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= `CPSB_PIN_IDLE;
      s2_q <= `CPSB_PIN_IDLE;
      s3_q <= `CPSB_PIN_IDLE;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filtered level and its previous value for edge finding
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      clean_q <= `CPSB_PIN_IDLE;
      clean_prev_q <= `CPSB_PIN_IDLE;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
      clean_prev_q <= clean_q;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic selected;
  logic sdi_lvl;
  logic xfer_rise;
  logic [3:0] sel_fall;
  // select is active low
  assign selected = ~clean_q[1];
  assign sdi_lvl = clean_q[2];
  // sdi rides the same pipeline as sck, so the two stay aligned
  // sck edges count only while selected
  // select gates clock
  assign sck_rise = selected & clean_q[0] & ~clean_prev_q[0];
  assign sck_fall = selected & ~clean_q[0] & clean_prev_q[0];
  // transfer strobe acts on its rising edge, select strobes on falling
  assign xfer_rise = clean_q[3] & ~clean_prev_q[3];
  assign sel_fall = ~clean_q[7:4] & clean_prev_q[7:4];

  ////////////////////////////////////////////////////////////////////////
  // 128-bit shift buffer, msb is first bit received (ch15 of image d)
  // no bit counter: a frame of any length simply shifts, and the
  // buffer keeps its contents until the next selected rising edge
  // msb first: the first bit received ends up in the top bit
  logic [BUF_BITS-1:0] buf_q;

  // word size irrelevant, order msb first
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      buf_q <= `CPSB_BUF_RESET;
    end else if (sck_rise) begin
      buf_q <= {buf_q[BUF_BITS-2:0], sdi_lvl};
    end
  end

  // sdo shows the bit that the next rising edge pushes out, so a
  // chained device captures exactly that bit on the same edge
  // far end out on fall for the chain
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sdo <= 1'b0;
    end else if (sck_fall) begin
      sdo <= buf_q[BUF_BITS-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer between the shift buffer and the image registers
  // a transfer strobe during a consumer stall would be lost without it
  logic [BUF_BITS-1:0] fifo_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;
  logic fifo_ready;
  logic fifo_valid;
  logic img_ready;
  assign fifo_ready = (count_q != 2'h2);
  assign fifo_valid = (count_q != 2'h0);
  // a transfer arriving while full is held until space frees
  logic xfer_pend_q;
  assign push = (xfer_rise | xfer_pend_q) & fifo_ready;
  assign pop = fifo_valid & img_ready;

  // pending transfer request
  // one request waits here while both entries are full
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      xfer_pend_q <= 1'b0;
    end else begin
      xfer_pend_q <= (xfer_rise | xfer_pend_q) & ~fifo_ready;
    end
  end

  // storage and pointers
  // write side fills at its pointer, read side only moves its pointer
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_q[0] <= `CPSB_BUF_RESET;
      fifo_q[1] <= `CPSB_BUF_RESET;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        fifo_q[wr_ptr_q] <= buf_q;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push && !pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop && !push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end

  // status of the buffer, visible to the outside
  // registered copy, one mclk behind the internal flag
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_valid <= 1'b0;
    end else begin
      word_valid <= fifo_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // image registers d, c, b, a
  logic [31:0] img_d_q;
  logic [31:0] img_c_q;
  logic [31:0] img_b_q;
  logic [31:0] img_a_q;
  logic [BUF_BITS-1:0] head;
  // head of the buffer is the oldest word
  assign head = fifo_q[rd_ptr_q];
  // images may load only when the output is not mid-update and consumer agrees
  cpsb_out_state_t ostate_q;
  assign img_ready = word_ready & (ostate_q == cpsb_out_run);

  // images hold their value until the next word is taken
  // slice buffer into images
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      img_d_q <= `CPSB_IMG_RESET;
      img_c_q <= `CPSB_IMG_RESET;
      img_b_q <= `CPSB_IMG_RESET;
      img_a_q <= `CPSB_IMG_RESET;
    end else if (pop) begin
      img_d_q <= head[`CPSB_D_MSB:`CPSB_D_LSB];
      img_c_q <= head[`CPSB_C_MSB:`CPSB_C_LSB];
      img_b_q <= head[`CPSB_B_MSB:`CPSB_B_LSB];
      img_a_q <= head[`CPSB_A_MSB:`CPSB_A_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output control register with blanking on update
  // a select strobe is ignored while blanking; strobes must be spaced by
  // the blank time plus one mclk to take effect
  logic [31:0] pending_q;
  logic [3:0] blank_cnt_q;
  logic [31:0] sel_img;

  // strobe priority a, b, c, d when several fall together
  // sel_img matters only in the cycle a strobe fall is seen
  always_comb begin
    sel_img = img_a_q;
    if (sel_fall[0]) begin
      sel_img = img_a_q;
    end else if (sel_fall[1]) begin
      sel_img = img_b_q;
    end else if (sel_fall[2]) begin
      sel_img = img_c_q;
    end else if (sel_fall[3]) begin
      sel_img = img_d_q;
    end
  end

  // every channel goes hiz first so none switches rail to rail
  // blank then load selected image
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ostate_q <= cpsb_out_run;
      pending_q <= `CPSB_OUT_HIZ;
      blank_cnt_q <= 4'h0;
      high_voltage_output <= `CPSB_OUT_HIZ;
    end else begin
      case (ostate_q)
        cpsb_out_run: begin
          if (sel_fall != 4'h0) begin
            pending_q <= sel_img;
            blank_cnt_q <= `CPSB_BLANK_CYCLES;
            high_voltage_output <= `CPSB_OUT_HIZ;
            ostate_q <= cpsb_out_blank;
          end
        end
        cpsb_out_blank: begin
          // last blank cycle: release the new pattern
          if (blank_cnt_q == 4'h1) begin
            high_voltage_output <= pending_q;
            ostate_q <= cpsb_out_run;
          end
          blank_cnt_q <= blank_cnt_q - 4'h1;
        end
        default: begin
          ostate_q <= cpsb_out_run;
        end
      endcase
    end
  end

  // the flag drops during blanking so the update is visible outside
  // registered from the output register, so it trails by one mclk
  // per-channel drive flag, code 00 is hiz
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      output_driven <= 16'h0;
    end else begin
      for (int ch = 0; ch < 16; ch++) begin
        if (ostate_q == cpsb_out_blank) begin
          output_driven[ch] <= 1'b0;
        end else begin
          output_driven[ch] <= (cpsb_code_t'(high_voltage_output[2*ch +: 2]) != cpsb_ch_hiz);
        end
      end
    end
  end

endmodule
`default_nettype wire

/* logic/cpsb_params.svh */
`ifndef CPSB_PARAMS_SVH
`define CPSB_PARAMS_SVH
`define CPSB_BUF_BITS 128
`define CPSB_IMG_BITS 32
`define CPSB_D_MSB 127
`define CPSB_D_LSB 96
`define CPSB_C_MSB 95
`define CPSB_C_LSB 64
`define CPSB_B_MSB 63
`define CPSB_B_LSB 32
`define CPSB_A_MSB 31
`define CPSB_A_LSB 0
`define CPSB_BUF_RESET 128'h0
`define CPSB_IMG_RESET 32'h0
`define CPSB_OUT_HIZ 32'h0
`define CPSB_CODE_HIZ 2'h0
`define CPSB_CODE_NEG 2'h1
`define CPSB_CODE_POS 2'h2
`define CPSB_CODE_GND 2'h3
`define CPSB_BLANK_CYCLES 4'h2
// pin idle levels: select strobes and ss_n high; sck, sdi and transfer strobe low
`define CPSB_PIN_IDLE 8'hf2
`endif

/* logic/cpsb_pkg.sv */
package cpsb_pkg;
  typedef enum logic [1:0] {
    cpsb_ch_hiz = 2'b00,
    cpsb_ch_neg = 2'b01,
    cpsb_ch_pos = 2'b10,
    cpsb_ch_gnd = 2'b11
  } cpsb_code_t;
  typedef enum logic [0:0] {
    cpsb_out_run = 1'b0,
    cpsb_out_blank = 1'b1
  } cpsb_out_state_t;
endpackage

/* testbench/cpsb_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cpsb_props #(parameter int BUF_BITS = 128) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic buffer_transfer_strobe,
  input wire logic select_image_a_strobe,
  input wire logic select_image_b_strobe,
  input wire logic select_image_c_strobe,
  input wire logic select_image_d_strobe,
  input wire logic [31:0] high_voltage_output,
  input wire logic [15:0] output_driven,
  input wire logic word_valid,
  input wire logic word_ready
);
  // all select strobes idle
  logic q;
  assign q = &{select_image_a_strobe, select_image_b_strobe, select_image_c_strobe, select_image_d_strobe};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  idle_sdo_a: assert property (ss_n [*8] |-> $stable(sdo)) else $error("sdo moved");
  // checked one edge later: the flops settle only at the first edge of the run
  rst_clear_a: assert property (disable iff (1'b0)
    sys_rst |=> {sdo, word_valid, output_driven, high_voltage_output} == '0) else $error("not cleared");
  out_hold_a: assert property (q [*8] |-> $stable(high_voltage_output)) else $error("output moved");
  drive_map_a: assert property (q [*8] |-> output_driven[0] == |high_voltage_output[1:0]
    && output_driven[15] == |high_voltage_output[31:30]) else $error("drive map");
  blank_d_a: assert property ($fell(select_image_d_strobe) |-> ##[1:8] output_driven == 16'h0)
    else $error("no blank");
  blank_a_a: assert property ($fell(select_image_a_strobe) |-> ##[1:8] output_driven == 16'h0)
    else $error("no blank");
  xfer_valid_a: assert property ($rose(buffer_transfer_strobe) && !word_ready |-> ##[2:8] word_valid)
    else $error("no word");
  word_hold_a: assert property (word_valid && !word_ready |=> word_valid) else $error("word lost");
endmodule
bind cpsb_shift_buffer cpsb_props #(.BUF_BITS(BUF_BITS)) i_props (.*);
`default_nettype wire

/* testbench/cpsb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module cpsb_host (
  input wire logic sdo,
  output logic sck,
  output logic ss_n,
  output logic sdi
);
  logic [255:0] got;
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    sdi = 1'b0;
  end
  // far data first, msb first
  // sdo is taken while sck is high: it holds the bit that this rise pushed out
  task automatic xfer(input logic [255:0] v, input int n, input int w, input logic sel_n);
    got = '0;
    ss_n = sel_n;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = v[i];
      #160 sck = 1'b1;
      #160 got = {got[254:0], sdo};
      sck = 1'b0;
      if (i % w == 0) #160;
    end
    #160 ss_n = 1'b1;
    // released line shows the inverse
    sdi = ~sdi;
    // select stays high a while so two frames never merge
    #160;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic word_ready = 1'b1;
  logic [4:0] st = 5'h0f;
  logic sck, ss_n, sdi, sdo, word_valid;
  logic [31:0] hv;
  logic [15:0] drv;
  logic [127:0] mb = '0;
  logic [31:0] img [4] = '{default: '0};
  int error_cnt = 0;
  int checks = 0;
  always #20 mclk = ~mclk;
  cpsb_shift_buffer i_dut (.mclk(mclk), .sys_rst(sys_rst), .sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo),
    .buffer_transfer_strobe(st[4]), .select_image_a_strobe(st[0]), .select_image_b_strobe(st[1]),
    .select_image_c_strobe(st[2]), .select_image_d_strobe(st[3]), .high_voltage_output(hv),
    .output_driven(drv), .word_valid(word_valid), .word_ready(word_ready));
  cpsb_host i_host (.sdo(sdo), .sck(sck), .ss_n(ss_n), .sdi(sdi));
  // compare and count
  task automatic cmp(input logic [255:0] g, input logic [255:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // model shifts the buffer, host moves the bits
  task automatic send(input logic [255:0] v, input int n, input int w);
    logic [255:0] e;
    e = '0;
    for (int i = n - 1; i >= 0; i--) begin
      e = {e[254:0], mb[127]};
      mb = {mb[126:0], v[i]};
    end
    i_host.xfer(v, n, w, 1'b0);
    cmp(i_host.got, e);
  endtask
  // toggle one strobe and let the result settle
  task automatic pulse(input int k);
    st[k] = ~st[k];
    #200 st[k] = ~st[k];
    #480;
  endtask
  function automatic logic [15:0] fdrv(input logic [31:0] x);
    for (int c = 0; c < 16; c++) fdrv[c] = |x[2*c +: 2];
  endfunction
  task automatic load();
    for (int k = 0; k < 4; k++) img[k] = mb[32*k +: 32];
  endtask
  task automatic show(input int k);
    pulse(k);
    cmp(hv, img[k]);
    cmp(drv, fdrv(img[k]));
  endtask
  // hang guard
  initial begin
    #2000000 error_cnt++;
    results();
  end
  initial begin
    logic [255:0] r;
    void'($urandom(6862));
    repeat (12) @(posedge mclk);
    #2 sys_rst = 1'b0;
    cmp({sdo, word_valid, drv, hv}, '0);
    #160 show(3);
    $display("test reset done");
    for (int w = 8; w <= 32; w *= 2) begin
      r = {$urandom, $urandom, $urandom, $urandom};
      if (w == 8) r = {8{16'he41b}};
      send(r, 128, w);
      pulse(4);
      load();
      for (int k = 0; k < 4; k++) show(k);
    end
    $display("test words done");
    // a deselected frame of inverted data must leave the buffer alone
    i_host.xfer(~r, 128, 32, 1'b1);
    send(r, 128, 32);
    $display("test deselect done");
    r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    send(r, 256, 16);
    $display("test chain done");
    word_ready = 1'b0;
    pulse(4);
    for (int i = 0; i < 20 && word_valid !== 1'b1; i++) #40;
    cmp(word_valid, 1'b1);
    if (word_valid !== 1'b1) results();
    show(3);
    word_ready = 1'b1;
    #240 load();
    show(3);
    $display("test stall done");
    sys_rst = 1'b1;
    #80 sys_rst = 1'b0;
    mb = '0;
    img = '{default: '0};
    #160 show(2);
    send(r, 128, 8);
    $display("test midreset done");
    results();
  end
endmodule
`default_nettype wire
